//--- relay_test_pkg.sv
// shared types and constants for the relay fault tester
package relay_test_pkg;

  // ---------------------------------------------------------------
  // structure
  // ---------------------------------------------------------------
  localparam int NUM_KERNELS = 3;
  localparam int DRIVES_PER_KERNEL = 2;
  localparam int NUM_RELAYS = 6;
  localparam int RELAY_IDX_W = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ = 125000000;
  localparam int INTERVAL_MIN_HOURS = 1;
  localparam int INTERVAL_MAX_HOURS = 3000;
  localparam int HOURS_W = 12;
  localparam longint SECONDS_PER_HOUR = 3600;
  localparam longint CYCLES_PER_HOUR = CLK_HZ * SECONDS_PER_HOUR;
  localparam int SETTLE_US = 20000;
  localparam longint SETTLE_CYCLES_L = (CLK_HZ / 1000000) * SETTLE_US;
  localparam int WAIT_W = 24;

  // ---------------------------------------------------------------
  // all-open and all-closed drive patterns
  // ---------------------------------------------------------------
  localparam logic [5:0] RELAYS_OPEN = 6'h00;
  localparam logic [5:0] RELAYS_CLOSED = 6'h3f;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // two discrete drive lines from each kernel
  typedef struct packed {
    logic [DRIVES_PER_KERNEL-1:0] kernel_c;
    logic [DRIVES_PER_KERNEL-1:0] kernel_b;
    logic [DRIVES_PER_KERNEL-1:0] kernel_a;
  } relay_drive_t;

  typedef struct packed {
    logic alarm;
    logic [RELAY_IDX_W-1:0] failed_relay;
    logic stuck_before;
    logic busy;
  } test_status_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CHECK,
    ST_TOGGLE,
    ST_RETURN,
    ST_HALTED
  } seq_state_t;

endpackage : relay_test_pkg

//--- sync_bits.sv
// two flip-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module sync_bits #(
  parameter int WIDTH = 6
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end
endmodule : sync_bits

//--- interval_timer.sv
// periodic tick generator counting hours of clock cycles
`timescale 1ns/1ps
module interval_timer #(
  parameter longint CYCLES_PER_HOUR = relay_test_pkg::CYCLES_PER_HOUR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [relay_test_pkg::HOURS_W-1:0] hours,
  output logic tick
);
  import relay_test_pkg::*;

  typedef struct packed {
    logic [39:0] cycles;
    logic [HOURS_W-1:0] hour_count;
    logic tick;
  } timer_state_t;

  timer_state_t state, next_state;
  logic [HOURS_W-1:0] clamped_hours;

  // clamp the interval into the programmable span
  always_comb begin
    clamped_hours = hours;
    if (hours < HOURS_W'(INTERVAL_MIN_HOURS)) begin
      clamped_hours = HOURS_W'(INTERVAL_MIN_HOURS);
    end else if (hours > HOURS_W'(INTERVAL_MAX_HOURS)) begin
      clamped_hours = HOURS_W'(INTERVAL_MAX_HOURS);
    end
  end

  // count cycles into hours, pulse when interval expires
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!run) begin
      next_state.cycles = '0;
      next_state.hour_count = '0;
    end else if (state.cycles == 40'(CYCLES_PER_HOUR - 1)) begin
      next_state.cycles = '0;
      if (state.hour_count + 1'b1 >= clamped_hours) begin
        next_state.hour_count = '0;
        next_state.tick = 1'b1;
      end else begin
        next_state.hour_count = state.hour_count + 1'b1;
      end
    end else begin
      next_state.cycles = state.cycles + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule : interval_timer

//--- redundant_relay_fault_tester.sv
// six-relay fault tolerant output with latent fault test sequencer
`timescale 1ns/1ps

// Notes on behaviour
// - six relays, three legs of two
// - each kernel drives two discrete outputs
// - commanded closed drives all six closed
// - commanded open drives all six open
// - per-output latent fault test enable
// - test starts periodically or on command
// - period programmable one to 3000 hours
// - each relay toggled opposite then back
// - only one relay toggled at once
// - readback checks position and movement
// - failure alarms, stops testing, output untouched
module redundant_relay_fault_tester #(
  parameter longint CYCLES_PER_HOUR = relay_test_pkg::CYCLES_PER_HOUR,
  parameter int SETTLE_CYCLES = int'(relay_test_pkg::SETTLE_CYCLES_L)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic output_closed_cmd,
  input wire logic test_enable,
  input wire logic test_command,
  input wire logic alarm_reset,
  input wire logic [relay_test_pkg::HOURS_W-1:0] interval_hours,
  input wire logic [relay_test_pkg::NUM_RELAYS-1:0] contact_readback,
  output relay_test_pkg::relay_drive_t relay_drive,
  output relay_test_pkg::test_status_t test_status
);
  import relay_test_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    seq_state_t seq;
    logic [RELAY_IDX_W-1:0] index;
    logic [WAIT_W-1:0] wait_count;
    logic target;
    logic cmd_prev;
    logic pending;
    logic [NUM_RELAYS-1:0] drive;
    test_status_t status;
  } tester_state_t;

  tester_state_t state, next_state;
  logic [NUM_RELAYS-1:0] contacts;
  logic [NUM_RELAYS-1:0] closed_sync;
  logic [NUM_RELAYS-1:0] cmd_sync;
  logic period_tick;
  logic command_sync;
  logic wait_done;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // readback pins and operator command come from outside
  sync_bits #(.WIDTH(NUM_RELAYS)) readback_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(contact_readback),
    .sync_out(contacts)
  );

  sync_bits #(.WIDTH(NUM_RELAYS)) command_sync_u (
    .clk(clk),
    .resetn(resetn),
    .async_in({{(NUM_RELAYS-2){1'b0}}, test_command, output_closed_cmd}),
    .sync_out(cmd_sync)
  );

  assign command_sync = cmd_sync[1];
  assign closed_sync = {NUM_RELAYS{cmd_sync[0]}};

  // ---------------------------------------------------------------
  // periodic schedule
  // ---------------------------------------------------------------
  // period runs only while testing is enabled and not halted
  interval_timer #(.CYCLES_PER_HOUR(CYCLES_PER_HOUR)) period_timer (
    .clk(clk),
    .resetn(resetn),
    .run(test_enable && state.seq != ST_HALTED),
    .hours(interval_hours),
    .tick(period_tick)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // drive pattern with one relay flipped from the demanded state
  function automatic logic [NUM_RELAYS-1:0] flip_one(
    input logic [NUM_RELAYS-1:0] base,
    input logic [RELAY_IDX_W-1:0] idx
  );
    logic [NUM_RELAYS-1:0] result;
    result = base;
    result[idx] = ~base[idx];
    return result;
  endfunction : flip_one

  assign wait_done = (state.wait_count == WAIT_W'(SETTLE_CYCLES - 1));

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.cmd_prev = command_sync;
    next_state.wait_count = state.wait_count + 1'b1;
    // latch a start request; a command edge and a period tick both queue it
    if (test_enable && ((command_sync && !state.cmd_prev)
        || period_tick)) begin
      next_state.pending = 1'b1;
    end
    // all relays follow the demanded output outside a toggle
    next_state.drive = closed_sync;
    case (state.seq)
      ST_IDLE: begin
        next_state.status.busy = 1'b0;
        next_state.wait_count = '0;
        if (state.pending && test_enable) begin
          next_state.pending = 1'b0;
          next_state.index = '0;
          next_state.target = cmd_sync[0];
          next_state.seq = ST_CHECK;
          next_state.status.busy = 1'b1;
        end else if (!test_enable) begin
          next_state.pending = 1'b0;
        end
      end
      ST_CHECK: begin
        // relay must sit in the demanded state before it is moved
        if (cmd_sync[0] != state.target || !test_enable) begin
          next_state.seq = ST_IDLE; // abandon if demand changes or testing is disabled
        end else if (wait_done) begin
          next_state.wait_count = '0;
          if (contacts[state.index] != state.target) begin
            next_state.status.alarm = 1'b1;
            next_state.status.stuck_before = 1'b1;
            next_state.status.failed_relay = state.index;
            next_state.seq = ST_HALTED;
          end else begin
            next_state.seq = ST_TOGGLE;
            next_state.drive = flip_one(closed_sync, state.index);
          end
        end
      end
      ST_TOGGLE: begin
        // momentary opposite state on this relay only
        next_state.drive = flip_one(closed_sync, state.index);
        if (cmd_sync[0] != state.target) begin
          next_state.seq = ST_IDLE;
          next_state.drive = closed_sync;
        end else if (wait_done) begin
          next_state.wait_count = '0;
          next_state.drive = closed_sync;
          if (contacts[state.index] == state.target) begin
            next_state.status.alarm = 1'b1;
            next_state.status.stuck_before = 1'b0;
            next_state.status.failed_relay = state.index;
            next_state.seq = ST_HALTED;
          end else begin
            next_state.seq = ST_RETURN;
          end
        end
      end
      ST_RETURN: begin
        // contact must come back before the next relay moves
        if (cmd_sync[0] != state.target) begin
          next_state.seq = ST_IDLE;
        end else if (wait_done) begin
          next_state.wait_count = '0;
          if (contacts[state.index] != state.target) begin
            next_state.status.alarm = 1'b1;
            next_state.status.stuck_before = 1'b1;
            next_state.status.failed_relay = state.index;
            next_state.seq = ST_HALTED;
          end else if (state.index == RELAY_IDX_W'(NUM_RELAYS - 1)) begin
            next_state.seq = ST_IDLE;
          end else begin
            next_state.index = state.index + 1'b1;
            next_state.seq = ST_TOGGLE;
            next_state.drive = flip_one(closed_sync,
                                        state.index + 1'b1);
          end
        end
      end
      ST_HALTED: begin
        // testing stays inhibited; output keeps following demand
        next_state.status.busy = 1'b0;
        next_state.pending = 1'b0;
        next_state.wait_count = '0;
        if (alarm_reset) begin
          next_state.status.alarm = 1'b0;
          next_state.seq = ST_IDLE;
        end
      end
      default: begin
        next_state.seq = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // relays 0-1 kernel a, 2-3 kernel b, 4-5 kernel c; legs pair a/b/c
  assign relay_drive.kernel_a = state.drive[1:0];
  assign relay_drive.kernel_b = state.drive[3:2];
  assign relay_drive.kernel_c = state.drive[5:4];
  assign test_status = state.status;
endmodule : redundant_relay_fault_tester

//--- relay_tester_asserts.sv
// assertion checker on the relay fault tester ports
`timescale 1ns/1ps
module relay_tester_asserts
  import relay_test_pkg::*;
#(
  parameter int SETTLE_CYCLES = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic output_closed_cmd,
  input wire logic test_enable,
  input wire logic test_command,
  input wire logic alarm_reset,
  input wire relay_drive_t relay_drive,
  input wire test_status_t test_status
);
  logic [5:0] drv;
  logic mixed;
  int run_len;
  assign drv = relay_drive;
  assign mixed = drv != RELAYS_OPEN && drv != RELAYS_CLOSED;
  // cycles spent with one relay off the demand pattern
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) run_len <= 0;
    else run_len <= mixed ? run_len + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_closed; output_closed_cmd [*5]; endsequence
  sequence s_open; !output_closed_cmd [*5]; endsequence
  sequence s_toggle; $rose(mixed); endsequence
  a_closed_all: assert property (s_closed ##0 !test_status.busy
    |-> drv == RELAYS_CLOSED) else $error("drive not all closed");
  a_open_all: assert property (s_open ##0 !test_status.busy
    |-> drv == RELAYS_OPEN) else $error("drive not all open");
  a_one_relay: assert property ($countones(drv) <= 1
    || $countones(drv) >= 5) else $error("two relays toggled");
  a_toggle_hold: assert property (s_toggle |-> mixed [*8])
    else $error("toggle too short");
  a_toggle_len: assert property ($fell(mixed)
    |-> run_len == SETTLE_CYCLES) else $error("toggle length wrong");
  a_cmd_start: assert property ($rose(test_command) && test_enable
    && !test_status.alarm && !test_status.busy |-> ##[1:8] test_status.busy)
    else $error("command did not start test");
  a_disabled_idle: assert property ((!test_enable) [*3]
    ##0 !test_status.busy |=> !test_status.busy)
    else $error("test ran while disabled");
  a_alarm_hold: assert property (test_status.alarm && !alarm_reset
    |=> test_status.alarm) else $error("alarm dropped");
  a_alarm_halt: assert property (test_status.alarm
    && $past(test_status.alarm) |-> !test_status.busy)
    else $error("test ran after alarm");
endmodule : relay_tester_asserts

bind redundant_relay_fault_tester relay_tester_asserts #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_asserts (.clk(clk), .resetn(resetn),
  .output_closed_cmd(output_closed_cmd), .test_enable(test_enable),
  .test_command(test_command), .alarm_reset(alarm_reset),
  .relay_drive(relay_drive), .test_status(test_status));

//--- relay_contacts_model.sv
// behavioural relays with contact readback and stuck injection
`timescale 1ns/1ps
module relay_contacts_model
  import relay_test_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire relay_drive_t relay_drive,
  input wire logic [NUM_RELAYS-1:0] stuck,
  output logic [NUM_RELAYS-1:0] contact_readback
);
  logic [NUM_RELAYS-1:0] coil;
  // contacts lag the coils one cycle, the drive two; stuck contacts freeze
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coil <= RELAYS_OPEN;
      contact_readback <= RELAYS_OPEN;
    end else begin
      coil <= relay_drive;
      contact_readback <= (coil & ~stuck) | (contact_readback & stuck);
    end
  end
endmodule : relay_contacts_model

//--- tb_top.sv
// self-checking bench for the relay fault tester
`timescale 1ns/1ps
module tb_top;
  import relay_test_pkg::*;
  logic clk, resetn, output_closed_cmd, test_enable, test_command;
  logic alarm_reset;
  logic [HOURS_W-1:0] interval_hours;
  logic [NUM_RELAYS-1:0] contact_readback, stuck;
  relay_drive_t relay_drive;
  test_status_t test_status;
  int miscompares = 0;
  int num_checks = 0;
  int n;
  bit seen;

  redundant_relay_fault_tester #(.CYCLES_PER_HOUR(50), .SETTLE_CYCLES(16))
    dut (.clk(clk), .resetn(resetn), .output_closed_cmd(output_closed_cmd),
    .test_enable(test_enable), .test_command(test_command),
    .alarm_reset(alarm_reset), .interval_hours(interval_hours),
    .contact_readback(contact_readback), .relay_drive(relay_drive),
    .test_status(test_status));
  relay_contacts_model partner (.clk(clk), .resetn(resetn),
    .relay_drive(relay_drive), .stuck(stuck),
    .contact_readback(contact_readback));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic conclude;
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic fire;
    test_command = 1'b1;
    step(4);
    test_command = 1'b0;
  endtask : fire

  task automatic wait_busy(input int lim, output bit got);
    got = 0;
    for (int i = 0; i < lim && !got; i++) begin
      step(1);
      got = test_status.busy === 1'b1;
    end
  endtask : wait_busy

  // follow one test, checking each relay is flipped alone, in order
  task automatic run_test(input logic [5:0] dem, output int cnt);
    logic [5:0] diff, last;
    bit got;
    cnt = 0;
    last = 6'h00;
    wait_busy(20, got);
    for (int i = 0; i < 600 && test_status.busy === 1'b1; i++) begin
      diff = relay_drive ^ dem;
      if (diff != 6'h00 && diff != last) begin
        chk("toggled relay", 6'h01 << cnt, diff);
        cnt++;
      end
      last = diff;
      step(1);
    end
  endtask : run_test

  task automatic t_demand;
    output_closed_cmd = 1'b1;
    step(6);
    chk("closed drive", RELAYS_CLOSED, relay_drive);
    chk("kernel b", 2'h3, relay_drive.kernel_b);
    output_closed_cmd = 1'b0;
    step(6);
    chk("open drive", RELAYS_OPEN, relay_drive);
  endtask : t_demand

  task automatic t_manual(input logic closed);
    output_closed_cmd = closed;
    test_enable = 1'b1;
    step(6);
    fire();
    run_test(closed ? RELAYS_CLOSED : RELAYS_OPEN, n);
    chk("relays tested", 16'h6, n);
    chk("alarm", 16'h0, test_status.alarm);
    test_enable = 1'b0;
  endtask : t_manual

  task automatic t_disabled;
    fire();
    wait_busy(60, seen);
    chk("busy when disabled", 16'h0, seen);
  endtask : t_disabled

  task automatic t_periodic;
    interval_hours = 12'h000;
    test_enable = 1'b1;
    wait_busy(200, seen);
    chk("periodic start", 16'h1, seen);
    interval_hours = 12'hbb8;
    run_test(RELAYS_OPEN, n);
    test_enable = 1'b0;
    chk("periodic relays", 16'h6, n);
  endtask : t_periodic

  task automatic t_stuck;
    output_closed_cmd = 1'b1;
    test_enable = 1'b1;
    step(6);
    // freeze relay 3 only once its contact has reached closed
    stuck = 6'h08;
    fire();
    for (int i = 0; i < 600 && test_status.alarm !== 1'b1; i++) step(1);
    chk("alarm", 16'h1, test_status.alarm);
    chk("failed relay", 16'h3, test_status.failed_relay);
    chk("stuck before", 16'h0, test_status.stuck_before);
    step(20);
    chk("drive held", RELAYS_CLOSED, relay_drive);
    fire();
    wait_busy(60, seen);
    chk("busy after alarm", 16'h0, seen);
    alarm_reset = 1'b1;
    step(1);
    alarm_reset = 1'b0;
    step(2);
    chk("alarm cleared", 16'h0, test_status.alarm);
    stuck = 6'h00;
    test_enable = 1'b0;
  endtask : t_stuck

  initial begin
    resetn = 1'b0;
    output_closed_cmd = 1'b0;
    test_enable = 1'b0;
    test_command = 1'b0;
    alarm_reset = 1'b0;
    interval_hours = 12'hbb8;
    stuck = 6'h00;
    step(16);
    resetn = 1'b1;
    step(4);
    chk("reset drive", RELAYS_OPEN, relay_drive);
    t_demand();
    t_manual(1'b1);
    t_manual(1'b0);
    t_disabled();
    t_periodic();
    t_stuck();
    conclude();
  end

  // watchdog against a hung sequence
  initial begin
    #160000;
    miscompares++;
    conclude();
  end
endmodule : tb_top
